// ### design/twr_dev.sv
`timescale 1ns/1ps
module twr_dev
  import twr_pkg::*;
#(
  parameter int unsigned NREG = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  twr_if.dev bus,
  output logic [LEN_8-1:0] o_reg8 [NREG],
  output logic [LEN_16-1:0] o_reg16 [NREG],
  output logic [LEN_24-1:0] o_reg24 [NREG],
  output logic [GAIN_W-1:0] o_if_gain,
  output logic o_load
);
  import twr_pkg::*;

  localparam int unsigned NPIN = 3;
  localparam int unsigned SYNC_W = 3;
  localparam int unsigned PIN_FR = 0;
  localparam int unsigned PIN_CK = 1;
  localparam int unsigned PIN_DT = 2;
  // frame idles high, clock and data low; reset to these so no false edge follows reset
  localparam logic [NPIN-1:0] PIN_IDLE = 3'h1;

  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_lvl;
  wire [NPIN-1:0] pin_new;
  logic fr_lvl;
  logic fr_new;
  logic ck_lvl;
  logic ck_new;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [LEN_24-1:0] sh_r;
  logic [LEN_24-1:0] sh_nxt;
  logic [LEN_8-1:0] reg8_r [NREG];
  logic [LEN_8-1:0] reg8_nxt [NREG];
  logic [LEN_16-1:0] reg16_r [NREG];
  logic [LEN_16-1:0] reg16_nxt [NREG];
  logic [LEN_24-1:0] reg24_r [NREG];
  logic [LEN_24-1:0] reg24_nxt [NREG];
  logic [GAIN_W-1:0] gain_r;
  logic [GAIN_W-1:0] gain_nxt;
  logic load_r;
  logic load_nxt;
  logic fr_fall;
  logic fr_rise;
  logic ck_rise;
  logic dt_val;
  logic wr8;
  logic wr16;
  logic wr24;
  logic [ADDR_W-1:0] tgt;

  // address sits in the two top bits of the last byte whatever the length
  function automatic logic [ADDR_W-1:0] addr_of(input logic [LEN_24-1:0] v);
    addr_of = v[ADDR_POS +: ADDR_W];
  endfunction

  // true when the counted edges equal the given register width
  function automatic logic len_is(input logic [CNT_W-1:0] c, input int unsigned w);
    len_is = (c == CNT_W'(w));
  endfunction

  assign pin_raw = {bus.sdata, bus.sclk, bus.frame_n};

  // per-pin filter keeps a glitch shorter than two samples from making an edge
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      logic [SYNC_W-1:0] s_r;
      logic [SYNC_W-1:0] s_nxt;
      logic lvl_r;
      logic lvl_nxt;
      always_comb begin
        s_nxt = {s_r[SYNC_W-2:0], pin_raw[g]};
        // level moves only once stages two and three agree
        lvl_nxt = (s_r[SYNC_W-2] == s_r[SYNC_W-1]) ? s_r[SYNC_W-1] : lvl_r;
      end
      always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
          s_r <= {SYNC_W{PIN_IDLE[g]}};
          lvl_r <= PIN_IDLE[g];
        end else if (i_ce) begin
          s_r <= s_nxt;
          lvl_r <= lvl_nxt;
        end
      end
      assign pin_lvl[g] = lvl_r;
      assign pin_new[g] = lvl_nxt;
    end
  endgenerate

  assign fr_lvl = pin_lvl[PIN_FR];
  assign fr_new = pin_new[PIN_FR];
  assign ck_lvl = pin_lvl[PIN_CK];
  assign ck_new = pin_new[PIN_CK];

  // edge and length decode, shared by the shifter, the registers and the strobe
  always_comb begin
    fr_fall = fr_lvl & ~fr_new;
    fr_rise = ~fr_lvl & fr_new;
    // only clock edges inside a frame count
    ck_rise = ~ck_lvl & ck_new & ~fr_lvl;
    dt_val = pin_lvl[PIN_DT];
    tgt = addr_of(sh_r);
    // a close with any other count writes nothing
    wr8 = fr_rise & len_is(cnt_r, LEN_8);
    wr16 = fr_rise & len_is(cnt_r, LEN_16);
    wr24 = fr_rise & len_is(cnt_r, LEN_24);
  end

  always_comb begin
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    if (fr_fall) begin
      cnt_nxt = '0;
      sh_nxt = '0;
    end else if (ck_rise) begin
      sh_nxt = {sh_r[LEN_24-2:0], dt_val};
      // saturate so overlong frames never alias a valid length
      if (cnt_r != {CNT_W{1'b1}}) begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      sh_r <= '0;
    end else if (i_ce) begin
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
    end
  end

  // whole register at once, never partial
  always_comb begin
    reg8_nxt = reg8_r;
    reg16_nxt = reg16_r;
    reg24_nxt = reg24_r;
    if (wr8) begin
      reg8_nxt[tgt] = sh_r[LEN_8-1:0];
    end
    if (wr16) begin
      reg16_nxt[tgt] = sh_r[LEN_16-1:0];
    end
    if (wr24) begin
      reg24_nxt[tgt] = sh_r;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NREG; i++) begin
        reg8_r[i] <= '0;
        reg16_r[i] <= '0;
        reg24_r[i] <= '0;
      end
    end else if (i_ce) begin
      reg8_r <= reg8_nxt;
      reg16_r <= reg16_nxt;
      reg24_r <= reg24_nxt;
    end
  end

  // gain and load strobe follow the register writes
  always_comb begin
    gain_nxt = gain_r;
    if (wr16 && tgt == ADDR_R16_GAIN) begin
      gain_nxt = sh_r[GAIN_LSB +: GAIN_W];
    end
    // held while the clock enable is low, so it spans one enabled cycle
    load_nxt = wr8 | wr16 | wr24;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      gain_r <= '0;
      load_r <= 1'b0;
    end else if (i_ce) begin
      gain_r <= gain_nxt;
      load_r <= load_nxt;
    end
  end

  assign o_reg8 = reg8_r;
  assign o_reg16 = reg16_r;
  assign o_reg24 = reg24_r;
  assign o_if_gain = gain_r;
  assign o_load = load_r;
endmodule

// ### design/twr_pkg.sv
package twr_pkg;
  localparam int unsigned CORE_CLK_MHZ = 125;
  // timing limits of the bus in ns, then the same rounded up to core clock cycles
  localparam int unsigned SCLK_HIGH_MIN_NS = 250;
  localparam int unsigned SCLK_LOW_MIN_NS = 250;
  localparam int unsigned SETUP_MIN_NS = 100;
  localparam int unsigned EN_HOLD_MIN_NS = 250;
  localparam int unsigned SCLK_HIGH_CYC = (SCLK_HIGH_MIN_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned SCLK_LOW_CYC = (SCLK_LOW_MIN_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned SETUP_CYC = (SETUP_MIN_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned EN_HOLD_CYC = (EN_HOLD_MIN_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned LEN_8 = 8;
  localparam int unsigned LEN_16 = 16;
  localparam int unsigned LEN_24 = 24;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned ADDR_W = 2;
  // address sits in the two top bits of the last byte
  localparam int unsigned ADDR_POS = 6;
  localparam int unsigned GAIN_LSB = 6;
  localparam int unsigned GAIN_W = 4;
  localparam int unsigned RSV_LSB = 2;
  localparam int unsigned RSV_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_N1 = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_N2 = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RDIV = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_R16_GAIN = 2'h3;
endpackage

// ### design/twr_if.sv
`timescale 1ns/1ps
interface twr_if;
  logic frame_n;
  logic sclk;
  logic sdata;
  modport host (output frame_n, output sclk, output sdata);
  modport dev (input frame_n, input sclk, input sdata);
endinterface

// ### design/twr_host.sv
`timescale 1ns/1ps
module twr_host
  import twr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic [CNT_W-1:0] i_len,
  input wire logic [LEN_24-1:0] i_data,
  twr_if.host bus,
  output logic o_busy,
  output logic o_done
);
  import twr_pkg::*;

  localparam int unsigned TW = 8;
  localparam logic [TW-1:0] T_SETUP = TW'(SETUP_CYC);
  localparam logic [TW-1:0] T_LOW = TW'(SCLK_LOW_CYC);
  localparam logic [TW-1:0] T_HIGH = TW'(SCLK_HIGH_CYC);
  localparam logic [TW-1:0] T_HOLD = TW'(EN_HOLD_CYC);

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETUP = 5'h02,
    ST_LOW = 5'h04,
    ST_HIGH = 5'h08,
    ST_HOLD = 5'h10
  } twr_st_t;

  twr_st_t st_r, st_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt;
  logic [CNT_W-1:0] left_r, left_nxt;
  logic [LEN_24-1:0] sh_r, sh_nxt;
  logic fr_r, fr_nxt, ck_r, ck_nxt, dt_r, dt_nxt, done_r, done_nxt;
  logic len_ok, busy_r, busy_nxt;

  always_comb begin
    st_nxt = st_r;
    tmr_nxt = (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
    left_nxt = left_r;
    sh_nxt = sh_r;
    fr_nxt = fr_r;
    ck_nxt = ck_r;
    dt_nxt = dt_r;
    done_nxt = 1'b0;
    len_ok = i_len == CNT_W'(LEN_8) || i_len == CNT_W'(LEN_16) || i_len == CNT_W'(LEN_24);
    unique case (st_r)
      ST_IDLE: begin
        // only the three legal lengths are sent, and only after the gap has run out
        if (i_start && len_ok && tmr_r == '0) begin
          // left-align so the first bit out is the top one
          sh_nxt = i_data << (CNT_W'(LEN_24) - i_len);
          left_nxt = i_len;
          fr_nxt = 1'b0;
          tmr_nxt = T_SETUP;
          st_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tmr_r == '0) begin
          dt_nxt = sh_r[LEN_24-1];
          sh_nxt = {sh_r[LEN_24-2:0], 1'b0};
          tmr_nxt = T_LOW;
          st_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        if (tmr_r == '0) begin
          ck_nxt = 1'b1;
          left_nxt = left_r - 1'b1;
          tmr_nxt = T_HIGH;
          st_nxt = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (tmr_r == '0) begin
          ck_nxt = 1'b0;
          if (left_r == '0) begin
            tmr_nxt = T_HOLD;
            st_nxt = ST_HOLD;
          end else begin
            tmr_nxt = T_SETUP;
            st_nxt = ST_SETUP;
          end
        end
      end
      ST_HOLD: begin
        if (tmr_r == '0) begin
          fr_nxt = 1'b1;
          // frame stays high long enough for the far end filter to see the close
          tmr_nxt = T_HOLD;
          done_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
    endcase
    busy_nxt = (st_nxt != ST_IDLE) || (tmr_nxt != '0);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_r <= ST_IDLE;
      tmr_r <= '0;
      left_r <= '0;
      sh_r <= '0;
      fr_r <= 1'b1;
      ck_r <= 1'b0;
      dt_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (i_ce) begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      left_r <= left_nxt;
      sh_r <= sh_nxt;
      fr_r <= fr_nxt;
      ck_r <= ck_nxt;
      dt_r <= dt_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign bus.frame_n = fr_r;
  assign bus.sclk = ck_r;
  assign bus.sdata = dt_r;
  assign o_busy = busy_r;
  assign o_done = done_r;
endmodule

// ### tb/twr_assertions.sv
`timescale 1ns/1ps
module twr_assertions (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic sdata
);
  import twr_pkg::*;
  logic [7:0] hi_r, hi_nxt, lo_r, lo_nxt, st_r, st_nxt;
  logic [4:0] n_r, n_nxt;
  logic sd_r;
  // saturating phase counters; a rise is sclk high after a counted low
  always_comb begin
    hi_nxt = sclk ? hi_r + 8'(hi_r != 8'hFF) : 8'h00;
    lo_nxt = sclk ? 8'h00 : lo_r + 8'(lo_r != 8'hFF);
    st_nxt = (sdata != sd_r) ? 8'h00 : st_r + 8'(st_r != 8'hFF);
    n_nxt = frame_n ? 5'h00 : n_r + 5'(sclk && lo_r != 8'h00 && n_r != 5'h1F);
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      {hi_r, lo_r, st_r, n_r, sd_r} <= '0;
    end else begin
      {hi_r, lo_r, st_r, n_r, sd_r} <= {hi_nxt, lo_nxt, st_nxt, n_nxt, sdata};
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_open; $fell(frame_n); endsequence
  sequence s_close; $rose(frame_n); endsequence
  AST_IDLE_CLK: assert property (frame_n |-> !sclk) else $error("sclk high outside frame");
  AST_DATA_HOLD: assert property (sclk && $past(sclk) |-> $stable(sdata)) else $error("sdata moved");
  AST_OPEN: assert property (s_open |-> (!frame_n && !sclk) [*8]) else $error("frame open too short");
  AST_HIGH: assert property ($fell(sclk) |-> hi_r >= SCLK_HIGH_CYC) else $error("sclk high short");
  AST_LOW: assert property ($rose(sclk) |-> lo_r >= SCLK_LOW_CYC) else $error("sclk low short");
  AST_SETUP: assert property ($rose(sclk) |-> st_r >= SETUP_CYC - 1) else $error("setup short");
  AST_EN_HOLD: assert property (s_close |-> lo_r >= EN_HOLD_CYC) else $error("frame hold short");
  AST_LEN: assert property (s_close |-> n_r inside {5'h08, 5'h10, 5'h18}) else $error("bad length");
  AST_GAP: assert property (s_close |=> frame_n) else $error("frame reopened at once");
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import twr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, start = 1'b0, busy, done, load, load2;
  logic [4:0] len = 5'h00;
  logic [23:0] data = 24'h000000, wsr = 24'h000000, msk;
  logic [7:0] r8 [4], b8 [4], m8 [4] = '{default: 8'h00};
  logic [15:0] r16 [4], m16 [4] = '{default: 16'h0000};
  logic [23:0] r24 [4], m24 [4] = '{default: 24'h000000};
  logic [3:0] gain;
  logic [28:0] q [$], e;
  int error_cnt = 0, n_checks = 0, cyc = 0, n_b = 0;
  twr_if bus();
  twr_if bad();
  initial forever #4 clk = ~clk;
  twr_host twr_host_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_start(start), .i_len(len),
    .i_data(data), .bus(bus.host), .o_busy(busy), .o_done(done));
  twr_dev twr_dev_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .bus(bus.dev), .o_reg8(r8),
    .o_reg16(r16), .o_reg24(r24), .o_if_gain(gain), .o_load(load));
  twr_dev twr_dev_i2 (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .bus(bad.dev), .o_reg8(b8),
    .o_reg16(), .o_reg24(), .o_if_gain(), .o_load(load2));
  twr_assertions twr_assertions_i (.i_core_clk(clk), .i_rst_n(rst_n), .frame_n(bus.frame_n),
    .sclk(bus.sclk), .sdata(bus.sdata));
  task automatic check(input string nm, input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic send(input logic [4:0] n, input logic [23:0] d);
    bit ok;
    ok = n inside {5'h08, 5'h10, 5'h18};
    for (int i = 0; i < 200 && busy === 1'b1; i++) @(posedge clk);
    if (ok) q.push_back({n, d});
    start <= 1'b1;
    len <= n;
    data <= d;
    for (int i = 0; i < 200 && busy !== 1'b1; i++) @(posedge clk);
    if (!ok) check("busy", 24'(busy), 24'h0);
    start <= 1'b0;
    for (int i = 0; ok && i < 9000 && done !== 1'b1; i++) @(posedge clk);
  endtask
  // far end driven by hand so that lengths the host refuses can still be sent
  task automatic raw(input int n, input logic [23:0] d);
    bad.frame_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      bad.sdata <= d[i];
      repeat (5) @(posedge clk);
      bad.sclk <= 1'b1;
      repeat (5) @(posedge clk);
      bad.sclk <= 1'b0;
    end
    repeat (5) @(posedge clk);
    bad.frame_n <= 1'b1;
    bad.sdata <= ~bad.sdata;
    repeat (10) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ce <= !rst_n || ($urandom % 4 != 0);
    if (load2 === 1'b1) n_b++;
    // a frozen strobe spans up to the first enabled edge; count it there
    if (load === 1'b1 && ce === 1'b1) begin
      if (q.size() == 0) check("spurious load", 24'h1, 24'h0);
      else begin
        e = q.pop_front();
        case (e[28:24])
          5'h08: m8[e[7:6]] = e[7:0];
          5'h10: m16[e[7:6]] = e[15:0];
          default: m24[e[7:6]] = e[23:0];
        endcase
      end
      for (int i = 0; i < 4; i++) begin
        check("reg8", 24'(r8[i]), 24'(m8[i]));
        check("reg16", 24'(r16[i]), 24'(m16[i]));
        check("reg24", r24[i], m24[i]);
      end
      check("gain", 24'(gain), 24'(m16[3][9:6]));
    end
    if (cyc == 90000) begin
      error_cnt++;
      stop_test();
    end
  end
  always @(posedge bus.sclk) wsr <= {wsr[22:0], bus.sdata};
  always @(posedge bus.frame_n) begin
    if (q.size() > 0) begin
      msk = (24'h1 << q[0][28:24]) - 24'h1;
      check("wire", wsr & msk, q[0][23:0] & msk);
    end
  end
  initial begin
    logic [23:0] d;
    bad.frame_n = 1'b1;
    bad.sclk = 1'b0;
    bad.sdata = 1'b0;
    d = $urandom(32'h277AA2AC);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int r = 0; r < 2; r++) begin
      for (int k = 1; k < 4; k++) begin
        for (int a = 0; a < 4; a++) begin
          d = $urandom;
          d[7:6] = 2'(a);
          if (k == 3) d[5:2] = 4'h0;
          send(5'(8 * k), d);
        end
      end
    end
    send(5'h0C, 24'hFFFFFF);
    send(5'h1F, 24'h000000);
    repeat (40) @(posedge clk);
    check("pending", 24'(q.size()), 24'h0);
    raw(5, 24'h00001F);
    raw(12, 24'h000FC0);
    raw(0, 24'h000000);
    raw(8, 24'h0000C5);
    check("bad loads", 24'(n_b), 24'h1);
    check("reg8 after abort", 24'(b8[3]), 24'h0000C5);
    check("reg8 untouched", 24'(b8[0]), 24'h0);
    stop_test();
  end
endmodule
